// ==== design/lcdcs_defs.svh ====
//----------------------------------------------------------------------
// Contract
//----------------------------------------------------------------------
// Contract
// - three clock sources: system clock /8192, timer1 crystal /32, lf oscillator /32.
// - the /8192 system clock divider is fixed; only the prescaler adjusts rate.
// - clock-select field at control bits 3:2 picks the source.
// - timer1 crystal and lf oscillator sources keep clocking during sleep.
// - 16-bit prescaler counter is not readable or writable by software.
// - four-bit prescale field selects frame clock division 1:1 to 1:16.
// - bias types: static two levels, half three levels, third four levels.
// - bias pin enable at bit 4 resets set; software clears it.
// - sleep-stop enable at bit 6: set stops in sleep, clear keeps running.
// - sleep with stop enable set halts at once and drives minimum voltage.
// - sleep with stop clear and sleep-capable clock keeps showing pixel data.
// - sleep operation only with lf oscillator or timer1 crystal sources.
// - pixel data stays frozen while the device sleeps.
// - module enable at bit 7 turns the block on, set last.
`ifndef LCDCS_DEFS_SVH
`define LCDCS_DEFS_SVH

// register byte offsets
`define LCDCS_OFS_CONTROL 8'h00
`define LCDCS_OFS_PRESCALE 8'h04
`define LCDCS_OFS_STATUS 8'h08
`define LCDCS_OFS_PIXEL 8'h0C

// control register fields
`define LCDCS_CTL_ON_BIT 7
`define LCDCS_CTL_SLPSTOP_BIT 6
`define LCDCS_CTL_BIASPIN_BIT 4
`define LCDCS_CTL_CS_HI 3
`define LCDCS_CTL_CS_LO 2
`define LCDCS_CTL_BIAS_HI 1
`define LCDCS_CTL_BIAS_LO 0

// reset values
`define LCDCS_CONTROL_RST 8'h13
`define LCDCS_PRESCALE_RST 4'h0
`define LCDCS_PIXEL_RST 8'h00

// divider counts
`define LCDCS_SYS_DIV 8192
`define LCDCS_OSC_DIV 32

`endif

// ==== design/lcdcs_pkg.sv ====
package lcdcs_pkg;

  // clock source select encodings
  typedef enum logic [1:0] {
    LCDCS_SRC_SYS = 2'b00,
    LCDCS_SRC_T1 = 2'b01,
    LCDCS_SRC_LF = 2'b10,
    LCDCS_SRC_LF2 = 2'b11
  } lcdcs_src_t;

  // bias configurations
  typedef enum logic [1:0] {
    LCDCS_BIAS_STATIC = 2'b00,
    LCDCS_BIAS_HALF = 2'b01,
    LCDCS_BIAS_THIRD = 2'b10,
    LCDCS_BIAS_THIRD2 = 2'b11
  } lcdcs_bias_t;

  // operating state of the driver
  typedef enum logic [1:0] {
    LCDCS_ST_OFF = 2'b00,
    LCDCS_ST_RUN = 2'b01,
    LCDCS_ST_SLEEP_RUN = 2'b10,
    LCDCS_ST_HALT = 2'b11
  } lcdcs_state_t;

endpackage

// ==== design/lcdcs_top.sv ====
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lcdcs_defs.svh"

module lcdcs_top
  import lcdcs_pkg::*;
(
  input wire logic REF_CLK_I, // 250 MHz system clock
  input wire logic RST_N_I, // async power-on reset, active low
  input wire logic WB_CYC_I, // wishbone cycle
  input wire logic WB_STB_I, // wishbone strobe
  input wire logic WB_WE_I, // wishbone write enable
  input wire logic [7:0] WB_ADR_I, // wishbone byte address
  input wire logic [3:0] WB_SEL_I, // wishbone byte lanes
  input wire logic [31:0] WB_DAT_I, // wishbone write data
  output logic [31:0] WB_DAT_O, // wishbone read data
  output logic WB_ACK_O, // wishbone acknowledge
  input wire logic SLEEP_I, // core is in sleep, level
  input wire logic TIMER1_CRYSTAL_OSC_CLK_I, // timer1 crystal oscillator pin
  input wire logic LFOSC_CLK_I, // low-frequency internal oscillator
  output logic FRAME_TICK_O, // one-cycle frame clock pulse
  output logic [7:0] SEG_DATA_O, // displayed pixel data
  output logic SEG_MIN_O, // drive minimum lcd voltage
  output logic LOW_POWER_O, // low-current state
  output logic BIAS_PIN_EN_O, // bias voltage pins enabled
  output logic [1:0] BIAS_TYPE_O, // bias configuration
  output logic [2:0] BIAS_LEVELS_O // number of bias voltage levels
);

  //--------------------------------------------------------------------
  // registers
  //--------------------------------------------------------------------
  logic [7:0] ctl_ff;
  logic [3:0] frame_prescale_sel_ff;
  logic [7:0] pixel_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [2:0] osc_sync_ff [2];
  logic osc_lvl_ff [2];
  logic [12:0] sys_cnt_ff;
  logic [4:0] osc_cnt_ff [2];
  logic [1:0] src_act_ff;
  logic [15:0] pre_cnt_ff;
  logic frame_tick_ff;
  logic [7:0] seg_ff;
  logic seg_min_ff;
  lcdcs_state_t state_ff;
  lcdcs_state_t nxt_state;

  logic lcd_module_on;
  logic lcd_sleep_stop_en;
  logic bias_pin_enable;
  logic [1:0] clk_sel;
  logic bus_req;
  logic wr_en;
  logic [2:0] osc_tick;
  logic sys_tick;
  logic src_tick;
  logic pre_wrap;
  logic running;

  // true when the selected source may keep running in sleep
  function automatic logic sleep_capable(input logic [1:0] sel);
    sleep_capable = (lcdcs_src_t'(sel) != LCDCS_SRC_SYS);
  endfunction

  // true when the current settings let the block operate
  function automatic logic may_run(input logic on, input logic slp,
                                   input logic stop, input logic [1:0] sel);
    may_run = on & (~slp | (~stop & sleep_capable(sel)));
  endfunction

  assign lcd_module_on = ctl_ff[`LCDCS_CTL_ON_BIT];
  assign lcd_sleep_stop_en = ctl_ff[`LCDCS_CTL_SLPSTOP_BIT];
  assign bias_pin_enable = ctl_ff[`LCDCS_CTL_BIASPIN_BIT];
  assign clk_sel = ctl_ff[`LCDCS_CTL_CS_HI:`LCDCS_CTL_CS_LO];

  //--------------------------------------------------------------------
  // wishbone slave
  //--------------------------------------------------------------------
  // one wait state: ack comes one edge after the request is seen
  assign bus_req = WB_CYC_I & WB_STB_I & ~ack_ff;
  // writes land at the acknowledge edge, the one edge at which the master samples ack
  assign wr_en = WB_CYC_I & WB_STB_I & ack_ff & WB_WE_I & WB_SEL_I[0];

  // acknowledge every address; unmapped ones read zero and drop writes
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ack_ff <= 1'b0;
    else
      ack_ff <= bus_req;
  end

  // read data captured with the acknowledge; the prescaler never shows
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rdat_ff <= 32'h0000_0000;
    else if (bus_req)
    begin
      case (WB_ADR_I)
        `LCDCS_OFS_CONTROL: rdat_ff <= {24'h00_0000, ctl_ff[7:6], 1'b0, ctl_ff[4:0]};
        `LCDCS_OFS_PRESCALE: rdat_ff <= {28'h000_0000, frame_prescale_sel_ff};
        `LCDCS_OFS_STATUS: rdat_ff <= {26'h000_0000, src_act_ff, 2'b00, state_ff};
        `LCDCS_OFS_PIXEL: rdat_ff <= {24'h00_0000, pixel_ff};
        default: rdat_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign WB_DAT_O = rdat_ff;
  assign WB_ACK_O = ack_ff;

  // control register; bias pins come up enabled after power-on
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ctl_ff <= `LCDCS_CONTROL_RST;
    else if (wr_en && WB_ADR_I == `LCDCS_OFS_CONTROL)
      ctl_ff <= {WB_DAT_I[7:6], 1'b0, WB_DAT_I[4:0]};
  end

  // prescale field, only handle software has on the prescaler
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      frame_prescale_sel_ff <= `LCDCS_PRESCALE_RST;
    else if (wr_en && WB_ADR_I == `LCDCS_OFS_PRESCALE)
      frame_prescale_sel_ff <= WB_DAT_I[3:0];
  end

  // pixel data; the core cannot write it while asleep
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      pixel_ff <= `LCDCS_PIXEL_RST;
    else if (wr_en && WB_ADR_I == `LCDCS_OFS_PIXEL && !SLEEP_I)
      pixel_ff <= WB_DAT_I[7:0];
  end

  //--------------------------------------------------------------------
  // clock sources
  //--------------------------------------------------------------------
  // fixed system clock divider, no software access to its ratio
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      sys_cnt_ff <= 13'h0000;
    else
      sys_cnt_ff <= sys_cnt_ff + 13'h0001;
  end
  assign sys_tick = (sys_cnt_ff == 13'(`LCDCS_SYS_DIV - 1));

  // oscillator pins pass three flops before any counter sees them
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_osc
      logic osc_pin;
      logic osc_edge;
      assign osc_pin = (g == 0) ? TIMER1_CRYSTAL_OSC_CLK_I : LFOSC_CLK_I;
      // a rising change counts once the second and third flops both show it
      assign osc_edge = osc_sync_ff[g][1] & osc_sync_ff[g][2] & ~osc_lvl_ff[g];

      always_ff @(posedge REF_CLK_I or negedge RST_N_I)
      begin
        if (!RST_N_I)
          osc_sync_ff[g] <= 3'b000;
        else
          osc_sync_ff[g] <= {osc_sync_ff[g][1:0], osc_pin};
      end

      // filtered level; it follows only when the second and third flops agree
      always_ff @(posedge REF_CLK_I or negedge RST_N_I)
      begin
        if (!RST_N_I)
          osc_lvl_ff[g] <= 1'b0;
        else if (osc_sync_ff[g][1] == osc_sync_ff[g][2])
          osc_lvl_ff[g] <= osc_sync_ff[g][2];
      end

      // divide by 32 in rising edges of the oscillator
      always_ff @(posedge REF_CLK_I or negedge RST_N_I)
      begin
        if (!RST_N_I)
          osc_cnt_ff[g] <= 5'h00;
        else if (osc_edge)
          osc_cnt_ff[g] <= osc_cnt_ff[g] + 5'h01;
      end

      assign osc_tick[g] = osc_edge && osc_cnt_ff[g] == 5'(`LCDCS_OSC_DIV - 1);
    end
  endgenerate
  assign osc_tick[2] = sys_tick;

  // source mux on the active select; code 11 also picks the lf oscillator
  always_comb
  begin
    case (lcdcs_src_t'(src_act_ff))
      LCDCS_SRC_SYS: src_tick = osc_tick[2];
      LCDCS_SRC_T1: src_tick = osc_tick[0];
      default: src_tick = osc_tick[1];
    endcase
  end

  //--------------------------------------------------------------------
  // prescaler and frame clock
  //--------------------------------------------------------------------
  assign running = (state_ff == LCDCS_ST_RUN) || (state_ff == LCDCS_ST_SLEEP_RUN);
  assign pre_wrap = src_tick && pre_cnt_ff >= {12'h000, frame_prescale_sel_ff};

  // 16-bit counter, wraps after field+1 source ticks; hidden from software
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      pre_cnt_ff <= 16'h0000;
    else if (!running)
      pre_cnt_ff <= 16'h0000;
    else if (pre_wrap)
      pre_cnt_ff <= 16'h0000;
    else if (src_tick)
      pre_cnt_ff <= pre_cnt_ff + 16'h0001;
  end

  // the select is adopted only at a prescaler wrap or while stopped,
  // so a source change never cuts a frame period short
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      src_act_ff <= 2'b00;
    else if (!running || pre_wrap)
      src_act_ff <= clk_sel;
  end

  // frame tick pulse, one cycle per prescaler wrap; a wrap in the cycle
  // of a stop is dropped so no pulse appears once halted
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      frame_tick_ff <= 1'b0;
    else
      frame_tick_ff <= running & pre_wrap &
                       ((nxt_state == LCDCS_ST_RUN) || (nxt_state == LCDCS_ST_SLEEP_RUN));
  end

  //--------------------------------------------------------------------
  // operating state
  //--------------------------------------------------------------------
  // halt takes the live select, so an unsafe source stops at once in sleep
  always_comb
  begin
    case (state_ff)
      LCDCS_ST_OFF,
      LCDCS_ST_RUN,
      LCDCS_ST_SLEEP_RUN,
      LCDCS_ST_HALT:
      begin
        if (!lcd_module_on)
          nxt_state = LCDCS_ST_OFF;
        else if (!may_run(lcd_module_on, SLEEP_I, lcd_sleep_stop_en, clk_sel))
          nxt_state = LCDCS_ST_HALT;
        else if (SLEEP_I)
          nxt_state = LCDCS_ST_SLEEP_RUN;
        else
          nxt_state = LCDCS_ST_RUN;
      end
      default: nxt_state = LCDCS_ST_OFF;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      state_ff <= LCDCS_ST_OFF;
    else
      state_ff <= nxt_state;
  end

  // segment drive: pixel data while running, minimum level otherwise
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      seg_ff <= 8'h00;
      seg_min_ff <= 1'b1;
    end
    else if (nxt_state == LCDCS_ST_RUN || nxt_state == LCDCS_ST_SLEEP_RUN)
    begin
      seg_ff <= pixel_ff;
      seg_min_ff <= 1'b0;
    end
    else
    begin
      seg_ff <= 8'h00;
      seg_min_ff <= 1'b1;
    end
  end

  //--------------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------------
  assign FRAME_TICK_O = frame_tick_ff;
  assign SEG_DATA_O = seg_ff;
  assign SEG_MIN_O = seg_min_ff;
  assign LOW_POWER_O = (state_ff == LCDCS_ST_HALT) & SLEEP_I;
  assign BIAS_PIN_EN_O = bias_pin_enable;
  assign BIAS_TYPE_O = ctl_ff[`LCDCS_CTL_BIAS_HI:`LCDCS_CTL_BIAS_LO];

  // level count per bias type
  always_comb
  begin
    case (lcdcs_bias_t'(BIAS_TYPE_O))
      LCDCS_BIAS_STATIC: BIAS_LEVELS_O = 3'd2;
      LCDCS_BIAS_HALF: BIAS_LEVELS_O = 3'd3;
      default: BIAS_LEVELS_O = 3'd4;
    endcase
  end

endmodule
`default_nettype wire

// ==== tb/lcdcs_osc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// free-running oscillators on the far side
// ----
module lcdcs_osc_model #(
  parameter realtime T1_HALF = 24.0,
  parameter realtime LF_HALF = 20.0
)(
  output logic t1_clk_o, // timer1 crystal
  output logic lf_clk_o // low-frequency oscillator
);
  // odd 1 ns phase keeps pin edges away from the system clock edges
  initial
  begin
    t1_clk_o = 1'b0;
    lf_clk_o = 1'b0;
    #1;
    fork
      forever #(T1_HALF) t1_clk_o = ~t1_clk_o;
      forever #(LF_HALF) lf_clk_o = ~lf_clk_o;
    join
  end
endmodule
`default_nettype wire

// ==== tb/lcdcs_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module lcdcs_checker (
  input wire logic REF_CLK_I, // clock
  input wire logic RST_N_I, // reset, active low
  input wire logic WB_CYC_I, // bus cycle
  input wire logic WB_STB_I, // bus strobe
  input wire logic WB_ACK_O, // bus ack
  input wire logic SLEEP_I, // core sleep
  input wire logic FRAME_TICK_O, // frame pulse
  input wire logic [7:0] SEG_DATA_O, // shown pixels
  input wire logic SEG_MIN_O, // minimum voltage
  input wire logic LOW_POWER_O, // low current
  input wire logic BIAS_PIN_EN_O, // bias pins on
  input wire logic [1:0] BIAS_TYPE_O, // bias type
  input wire logic [2:0] BIAS_LEVELS_O // bias levels
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // bus handshake: one answer, one cycle later, one cycle long
  ack_next_cycle_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  bias_levels_a: assert property (BIAS_LEVELS_O == (BIAS_TYPE_O == 2'h0 ? 3'h2 :
    BIAS_TYPE_O == 2'h1 ? 3'h3 : 3'h4))
    else $error("bias levels wrong");
  reset_pins_a: assert property (!$past(RST_N_I) |-> BIAS_PIN_EN_O && SEG_MIN_O)
    else $error("reset outputs wrong");
  // halted output must sit at minimum voltage with no frame activity
  halt_outputs_a: assert property (LOW_POWER_O |-> SEG_MIN_O && SEG_DATA_O == 8'h00 &&
    !FRAME_TICK_O)
    else $error("halt outputs wrong");
  halt_sleep_a: assert property (LOW_POWER_O |-> SLEEP_I && $past(SLEEP_I))
    else $error("low power while awake");
  tick_pulse_a: assert property (FRAME_TICK_O |=> !FRAME_TICK_O)
    else $error("frame tick too long");
  sleep_freeze_a: assert property (SLEEP_I && $past(SLEEP_I) && !LOW_POWER_O
    |-> $stable(SEG_DATA_O))
    else $error("pixels moved in sleep");
  cover property (FRAME_TICK_O && SLEEP_I);
  cover property (LOW_POWER_O);
  cover property (WB_ACK_O);
endmodule
bind lcdcs_top lcdcs_checker u_chk (.REF_CLK_I, .RST_N_I, .WB_CYC_I, .WB_STB_I, .WB_ACK_O,
  .SLEEP_I, .FRAME_TICK_O, .SEG_DATA_O, .SEG_MIN_O, .LOW_POWER_O, .BIAS_PIN_EN_O,
  .BIAS_TYPE_O, .BIAS_LEVELS_O);
`default_nettype wire

// ==== tb/lcdcs_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// self-checking bench
// ----
module lcdcs_top_bench;
  import lcdcs_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, slp = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, tick, smin, lowp, bpen, t1c, lfc;
  logic [7:0] seg;
  logic [1:0] btype;
  logic [2:0] blev;
  logic [31:0] expq[$];
  int miscompares = 0, tests_run = 0;
  logic [7:0] ctl[5] = '{8'hD8, 8'h98, 8'h94, 8'h90, 8'hD4};
  logic lp[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  always #2 clk = ~clk;
  lcdcs_osc_model u_osc (.t1_clk_o(t1c), .lf_clk_o(lfc));
  lcdcs_top u_dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .SLEEP_I(slp), .TIMER1_CRYSTAL_OSC_CLK_I(t1c), .LFOSC_CLK_I(lfc),
    .FRAME_TICK_O(tick), .SEG_DATA_O(seg), .SEG_MIN_O(smin), .LOW_POWER_O(lowp),
    .BIAS_PIN_EN_O(bpen), .BIAS_TYPE_O(btype), .BIAS_LEVELS_O(blev));
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one classic cycle; on a read d is the expected value, noted for the monitor
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    if (!w)
      expq.push_back({24'h0, d});
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
    begin
      miscompares++;
      conclude();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // cycles up to the next frame pulse, bounded so a dead clock ends the run
  task automatic wait_tick(output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (tick !== 1'b1 && n < 20000);
    if (tick !== 1'b1)
    begin
      miscompares++;
      conclude();
    end
  endtask
  // read data is judged in the ack cycle against the oldest note
  always @(posedge clk)
  begin
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
      chk("read data", rdat, expq.pop_front());
  end
  initial
  begin
    int n, p;
    void'($urandom(63635));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 8'h00, 8'h13);
    wb(1'b0, 8'h04, 8'h00);
    wb(1'b0, 8'h10, 8'h00);
    // frame spacing for every source code, module off while reconfiguring
    for (int s = 0; s < 4; s++)
    begin
      p = (s == 0) ? 0 : (s == 1) ? 15 : $urandom_range(15);
      wb(1'b1, 8'h00, 8'h10);
      wb(1'b1, 8'h04, p[7:0]);
      wb(1'b0, 8'h04, p[7:0]);
      wb(1'b1, 8'h00, {4'h9, s[1:0], 2'h0});
      wait_tick(n);
      wait_tick(n);
      chk("frame interval", n, (p + 1) * (s == 0 ? 8192 : s == 1 ? 384 : 320));
    end
    wb(1'b1, 8'h0C, 8'hA5);
    wb(1'b1, 8'h04, 8'h00);
    // sleep behaviour per stop bit and source, entered right after a frame pulse
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      slp <= 1'b0;
      wb(1'b1, 8'h00, ctl[i]);
      wait_tick(n);
      slp <= 1'b1;
      repeat (2) @(posedge clk);
      chk("low power", lowp, lp[i]);
      chk("seg min", smin, lp[i]);
      chk("seg data", seg, lp[i] ? 8'h00 : 8'hA5);
      if (!lp[i])
      begin
        wb(1'b1, 8'h0C, 8'h5A);
        wb(1'b0, 8'h0C, 8'hA5);
        wait_tick(n);
      end
      wb(1'b0, 8'h08, {2'b00, ctl[i][3:2], 2'b00, lp[i] ? 2'b11 : 2'b10});
    end
    @(posedge clk);
    slp <= 1'b0;
    for (int b = 0; b < 4; b++)
    begin
      wb(1'b1, 8'h00, {6'h00, b[1:0]});
      wb(1'b0, 8'h00, {6'h00, b[1:0]});
      chk("bias levels", blev, b == 0 ? 2 : b == 1 ? 3 : 4);
      chk("bias pins", bpen, 0);
      chk("bias type", btype, b);
    end
    conclude();
  end
endmodule
`default_nettype wire
